//--- dma_reqsel_pkg.sv
// Package for the DMA request-source selector: register map, field layout,
// selector codes and the request bundle carried between the blocks.
// Assumes a single core clock domain and a plain strobe-style register port.
package dma_reqsel_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [11:0] CHAN0_TO_3_REQUEST_SELECT_OFFSET = 12'h480;
   localparam logic [11:0] CHAN4_REQUEST_SELECT_OFFSET      = 12'h484;
   localparam logic [31:0] CHAN0_TO_3_REQUEST_SELECT_RESET  = 32'h00000000;
   localparam logic [31:0] CHAN4_REQUEST_SELECT_RESET       = 32'h00000000;

   // ----------------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------------
   localparam int CODE_WIDTH  = 6;
   localparam int CHAN0_LSB   = 0;
   localparam int CHAN1_LSB   = 8;
   localparam int CHAN2_LSB   = 16;
   localparam int CHAN3_LSB   = 24;
   localparam int CHAN4_LSB   = 0;
   localparam int NUM_CHANNELS = 5;
   localparam int NUM_SOURCES  = 30;

   // ----------------------------------------------------------------------
   // Selector codes
   // ----------------------------------------------------------------------
   localparam logic [5:0] CODE_DISABLED    = 6'h00;
   localparam logic [5:0] CODE_SERIAL_BASE = 6'h04;
   localparam logic [5:0] CODE_SERIAL_LAST = 6'h09;
   localparam logic [5:0] CODE_SPI_BASE    = 6'h10;
   localparam logic [5:0] CODE_SPI_LAST    = 6'h13;
   localparam logic [5:0] CODE_ADC         = 6'h14;
   localparam logic [5:0] CODE_PWM_BASE    = 6'h15;
   localparam logic [5:0] CODE_PWM_LAST    = 6'h1A;
   localparam logic [5:0] CODE_I2C_BASE    = 6'h1C;
   localparam logic [5:0] CODE_I2C_LAST    = 6'h1F;
   localparam logic [5:0] CODE_TIMER_BASE  = 6'h20;
   localparam logic [5:0] CODE_TIMER_LAST  = 6'h23;

   // All peripheral request lines, one bit each.
   typedef struct packed {
      logic serial_a_tx_request;
      logic serial_a_rx_request;
      logic serial_b_tx_request;
      logic serial_b_rx_request;
      logic serial_c_tx_request;
      logic serial_c_rx_request;
      logic spi_a_tx_request;
      logic spi_a_rx_request;
      logic spi_b_tx_request;
      logic spi_b_rx_request;
      logic adc_rx_request;
      logic pwm_a_pair1_capture_request;
      logic pwm_a_pair2_capture_request;
      logic pwm_a_pair3_capture_request;
      logic pwm_b_pair1_capture_request;
      logic pwm_b_pair2_capture_request;
      logic pwm_b_pair3_capture_request;
      logic i2c_a_tx_request;
      logic i2c_a_rx_request;
      logic i2c_b_tx_request;
      logic i2c_b_rx_request;
      logic timer_a_event_request;
      logic timer_b_event_request;
      logic timer_c_event_request;
      logic timer_d_event_request;
   } periph_requests_s;

   // Register port carried as one bundle.
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        write;
      logic        read;
   } reg_access_s;

endpackage : dma_reqsel_pkg

//--- dma_source_mux.sv
// One channel's request multiplexer: picks the request named by a selector
// code, or nothing for code 0 and reserved codes.
// Assumes the requests are synchronised to the core clock.
module dma_source_mux
   import dma_reqsel_pkg::*;
(
   // Selection
   input  wire logic [5:0]       code_in,
   input  wire logic             mem_to_mem_in,
   // Requests
   input  wire periph_requests_s requests_in,
   output logic                  request_out,
   output logic                  selected_out
);

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   always_comb begin
      request_out  = 1'b0;
      selected_out = 1'b1;
      case (code_in)
         6'h04: request_out = requests_in.serial_a_tx_request;
         6'h05: request_out = requests_in.serial_a_rx_request;
         6'h06: request_out = requests_in.serial_b_tx_request;
         6'h07: request_out = requests_in.serial_b_rx_request;
         6'h08: request_out = requests_in.serial_c_tx_request;
         6'h09: request_out = requests_in.serial_c_rx_request;
         6'h10: request_out = requests_in.spi_a_tx_request;
         6'h11: request_out = requests_in.spi_a_rx_request;
         6'h12: request_out = requests_in.spi_b_tx_request;
         6'h13: request_out = requests_in.spi_b_rx_request;
         CODE_ADC: request_out = requests_in.adc_rx_request;
         6'h15: request_out = requests_in.pwm_a_pair1_capture_request;
         6'h16: request_out = requests_in.pwm_a_pair2_capture_request;
         6'h17: request_out = requests_in.pwm_a_pair3_capture_request;
         6'h18: request_out = requests_in.pwm_b_pair1_capture_request;
         6'h19: request_out = requests_in.pwm_b_pair2_capture_request;
         6'h1A: request_out = requests_in.pwm_b_pair3_capture_request;
         6'h1C: request_out = requests_in.i2c_a_tx_request;
         6'h1D: request_out = requests_in.i2c_a_rx_request;
         6'h1E: request_out = requests_in.i2c_b_tx_request;
         6'h1F: request_out = requests_in.i2c_b_rx_request;
         6'h20: request_out = requests_in.timer_a_event_request;
         6'h21: request_out = requests_in.timer_b_event_request;
         6'h22: request_out = requests_in.timer_c_event_request;
         6'h23: request_out = requests_in.timer_d_event_request;
         default: begin
            request_out  = 1'b0;
            selected_out = 1'b0;
         end
      endcase
      // A memory-to-memory channel neither needs nor looks at a request.
      if (mem_to_mem_in) begin
         request_out  = 1'b0;
         selected_out = 1'b0;
      end
   end

endmodule : dma_source_mux

//--- dma_request_source_select.sv
// Request-source selector of a five-channel peripheral DMA controller:
// selector registers, per-channel routing and a source-conflict flag.
// Assumes peripheral requests arrive from outside the core clock domain and
// that the channel engine gives a memory-to-memory flag per channel.

// Notes on behaviour
// - Channel 0 has a 6-bit selector at bits 5:0 and code 0 routes no request.
// - Codes 4 to 9 route serial a, b and c transmit then receive requests.
// - Codes 16 to 19 route spi a transmit, a receive, b transmit, b receive.
// - Code 20 routes the converter result request.
// - Codes 21 to 26 route the capture requests of pairs 1 to 3 of pwm a then pwm b.
// - Codes 28 to 31 route i2c a transmit, a receive, b transmit, b receive.
// - Codes 32 to 35 route the events of timers a to d.
// - A memory-to-memory channel ignores its selector and needs no request.
// - Channels 1 to 3 have selectors at bits 13:8, 21:16 and 29:24.
// - Channel 4 has its selector at bits 5:0 of a second register.
module dma_request_source_select
   import dma_reqsel_pkg::*;
(
   // Clock and reset
   input  wire logic                    core_clk_in,
   input  wire logic                    reset_n_in,
   // Register port
   input  wire logic [11:0]             reg_addr_in,
   input  wire logic [31:0]             reg_wdata_in,
   input  wire logic                    reg_write_in,
   input  wire logic                    reg_read_in,
   output logic      [31:0]             reg_rdata_out,
   // Peripheral requests and channel engine
   input  wire periph_requests_s        requests_in,
   input  wire logic [NUM_CHANNELS-1:0] mem_to_mem_in,
   output logic      [NUM_CHANNELS-1:0] channel_request_out,
   output logic      [NUM_CHANNELS-1:0] channel_selected_out,
   output logic                         source_conflict_out
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [5:0]             source_code [NUM_CHANNELS];
   periph_requests_s       request_meta;
   periph_requests_s       request_sync;
   logic [NUM_CHANNELS-1:0] next_request;
   logic [NUM_CHANNELS-1:0] next_selected;
   logic                   next_conflict;

   function automatic logic [5:0] field_of(input logic [31:0] word, input int lsb);
      field_of = word[lsb +: CODE_WIDTH];
   endfunction : field_of

   // ----------------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         source_code[0] <= CHAN0_TO_3_REQUEST_SELECT_RESET[CHAN0_LSB +: CODE_WIDTH];
         source_code[1] <= CHAN0_TO_3_REQUEST_SELECT_RESET[CHAN1_LSB +: CODE_WIDTH];
         source_code[2] <= CHAN0_TO_3_REQUEST_SELECT_RESET[CHAN2_LSB +: CODE_WIDTH];
         source_code[3] <= CHAN0_TO_3_REQUEST_SELECT_RESET[CHAN3_LSB +: CODE_WIDTH];
         source_code[4] <= CHAN4_REQUEST_SELECT_RESET[CHAN4_LSB +: CODE_WIDTH];
      end else if (reg_write_in) begin
         if (reg_addr_in == CHAN0_TO_3_REQUEST_SELECT_OFFSET) begin
            source_code[0] <= field_of(reg_wdata_in, CHAN0_LSB);
            source_code[1] <= field_of(reg_wdata_in, CHAN1_LSB);
            source_code[2] <= field_of(reg_wdata_in, CHAN2_LSB);
            source_code[3] <= field_of(reg_wdata_in, CHAN3_LSB);
         end
         if (reg_addr_in == CHAN4_REQUEST_SELECT_OFFSET) begin
            source_code[4] <= field_of(reg_wdata_in, CHAN4_LSB);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------------
   // Reserved bits and unmapped addresses read as zero.
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= 32'h00000000;
      end else if (reg_read_in) begin
         case (reg_addr_in)
            CHAN0_TO_3_REQUEST_SELECT_OFFSET:
               reg_rdata_out <= {2'h0, source_code[3], 2'h0, source_code[2],
                                 2'h0, source_code[1], 2'h0, source_code[0]};
            CHAN4_REQUEST_SELECT_OFFSET:
               reg_rdata_out <= {26'h0000000, source_code[4]};
            default:
               reg_rdata_out <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_out <= 32'h00000000;
      end
   end

   // ----------------------------------------------------------------------
   // Request synchroniser
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         request_meta <= '0;
         request_sync <= '0;
      end else begin
         request_meta <= requests_in;
         request_sync <= request_meta;
      end
   end

   // ----------------------------------------------------------------------
   // Per-channel routing
   // ----------------------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      dma_source_mux u_mux (
         .code_in       (source_code[ch]),
         .mem_to_mem_in (mem_to_mem_in[ch]),
         .requests_in   (request_sync),
         .request_out   (next_request[ch]),
         .selected_out  (next_selected[ch])
      );
   end

   // Two live channels naming one source break the software contract; flag it
   // so the fault is visible rather than silently double-serving a request.
   always_comb begin
      next_conflict = 1'b0;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         for (int j = i + 1; j < NUM_CHANNELS; j++) begin
            if (next_selected[i] && next_selected[j] &&
                source_code[i] == source_code[j]) begin
               next_conflict = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         channel_request_out  <= '0;
         channel_selected_out <= '0;
         source_conflict_out  <= 1'b0;
      end else begin
         channel_request_out  <= next_request;
         channel_selected_out <= next_selected;
         source_conflict_out  <= next_conflict;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_disabled_quiet: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (source_code[0] == CODE_DISABLED) |=> !channel_request_out[0])
      else $error("channel 0 requests with code zero");

   a_serial_route: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (source_code[1] == 6'h05 && !mem_to_mem_in[1]) |=>
      channel_request_out[1] == $past(request_sync.serial_a_rx_request))
      else $error("serial route wrong");

   a_spi_route: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (source_code[2] == 6'h12 && !mem_to_mem_in[2]) |=>
      channel_request_out[2] == $past(request_sync.spi_b_tx_request))
      else $error("spi route wrong");

   a_adc_route: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (source_code[0] == CODE_ADC && !mem_to_mem_in[0]) |=>
      channel_request_out[0] == $past(request_sync.adc_rx_request))
      else $error("adc route wrong");

   a_pwm_route: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (source_code[3] == 6'h18 && !mem_to_mem_in[3]) |=>
      channel_request_out[3] == $past(request_sync.pwm_b_pair1_capture_request))
      else $error("pwm route wrong");

   a_i2c_route: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (source_code[4] == 6'h1D && !mem_to_mem_in[4]) |=>
      channel_request_out[4] == $past(request_sync.i2c_a_rx_request))
      else $error("i2c route wrong");

   a_timer_route: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (source_code[0] == 6'h23 && !mem_to_mem_in[0]) |=>
      channel_request_out[0] == $past(request_sync.timer_d_event_request))
      else $error("timer route wrong");

   a_reserved_quiet: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (source_code[1] == 6'h1B || source_code[1] > CODE_TIMER_LAST) |=>
      !channel_request_out[1] && !channel_selected_out[1])
      else $error("reserved code routes a request");

   a_memcopy_ignore: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      mem_to_mem_in[2] |=> !channel_request_out[2] && !channel_selected_out[2])
      else $error("memory copy channel routed");

   a_field_store: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (reg_write_in && reg_addr_in == CHAN0_TO_3_REQUEST_SELECT_OFFSET) |=>
      source_code[2] == $past(reg_wdata_in[21:16]))
      else $error("channel 2 field not stored");

   a_chan4_read: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (reg_read_in && reg_addr_in == CHAN4_REQUEST_SELECT_OFFSET) |=>
      reg_rdata_out == {26'h0000000, $past(source_code[4])})
      else $error("channel 4 readback wrong");

endmodule : dma_request_source_select

//--- periph_request_model.sv
// Behavioural model of the on-chip peripherals that raise DMA requests.
// Assumes the bench gives one pattern bit per request line, in struct order.
module periph_request_model
   import dma_reqsel_pkg::*;
#(
   parameter int SKEW_NS = 7
)
(
   // Clock
   input  wire logic             core_clk_in,
   // Stimulus
   input  wire logic [24:0]      pattern_in,
   // Request lines
   output periph_requests_s      requests_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------------
   // Request lines
   // ----------------------------------------------------------------------
   // Peripherals run on their own clocks, so their lines move a few
   // nanoseconds off the core edge; the selector must synchronise them.
   initial begin
      requests_out = '0;
   end

   always @(posedge core_clk_in) begin
      requests_out <= #(SKEW_NS) periph_requests_s'(pattern_in);
   end
endmodule : periph_request_model

//--- testbench.sv
// Self-checking bench for the DMA request-source selector.
// Assumes the selector and its package, and the peripheral request model.
module testbench
   import dma_reqsel_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------
   logic                    core_clk_in;
   logic                    reset_n_in;
   logic [11:0]             reg_addr_in;
   logic [31:0]             reg_wdata_in;
   logic                    reg_write_in;
   logic                    reg_read_in;
   logic [31:0]             reg_rdata_out;
   periph_requests_s        requests_in;
   logic [24:0]             pattern;
   logic [NUM_CHANNELS-1:0] mem_to_mem_in;
   logic [NUM_CHANNELS-1:0] channel_request_out;
   logic [NUM_CHANNELS-1:0] channel_selected_out;
   logic                    source_conflict_out;
   int                      n_errors;
   int                      total_checks;

   dma_request_source_select dut_u (
      .core_clk_in          (core_clk_in),
      .reset_n_in           (reset_n_in),
      .reg_addr_in          (reg_addr_in),
      .reg_wdata_in         (reg_wdata_in),
      .reg_write_in         (reg_write_in),
      .reg_read_in          (reg_read_in),
      .reg_rdata_out        (reg_rdata_out),
      .requests_in          (requests_in),
      .mem_to_mem_in        (mem_to_mem_in),
      .channel_request_out  (channel_request_out),
      .channel_selected_out (channel_selected_out),
      .source_conflict_out  (source_conflict_out)
   );

   periph_request_model peer_u (
      .core_clk_in  (core_clk_in),
      .pattern_in   (pattern),
      .requests_out (requests_in)
   );

   // ----------------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------------
   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_chan(input string what, input logic [4:0] exp, input logic [4:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask : check_chan

   task automatic reg_write(input logic [11:0] addr, input logic [31:0] data);
      @(posedge core_clk_in);
      reg_write_in <= 1'b1;
      reg_addr_in  <= addr;
      reg_wdata_in <= data;
      @(posedge core_clk_in);
      reg_write_in <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [11:0] addr, output logic [31:0] data);
      @(posedge core_clk_in);
      reg_read_in <= 1'b1;
      reg_addr_in <= addr;
      @(posedge core_clk_in);
      reg_read_in <= 1'b0;
      #1;
      data = reg_rdata_out;
   endtask : reg_read

   // Two sync flops, the output flop and the peers' skew all fit in six edges.
   task automatic drive(input logic [24:0] p);
      @(posedge core_clk_in);
      pattern <= p;
      repeat (6) @(posedge core_clk_in);
      #1;
   endtask : drive

   // Bit of the request vector routed by a code, or -1 for no source.
   function automatic int src_bit(input int code);
      if (code >= 4 && code <= 9) return 24 - (code - 4);
      if (code >= 16 && code <= 26) return 18 - (code - 16);
      if (code >= 28 && code <= 35) return 7 - (code - 28);
      return -1;
   endfunction : src_bit

   // Only one channel holds a nonzero code, so no source is shared.
   task automatic program_code(input int ch, input logic [5:0] code);
      logic [31:0] w0;
      logic [31:0] w4;
      w0 = 32'h0;
      w4 = 32'h0;
      if (ch == 4) w4[5:0] = code;
      else w0[ch*8 +: 6] = code;
      reg_write(12'h480, w0);
      reg_write(12'h484, w4);
   endtask : program_code

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic test_registers();
      logic [31:0] d;
      reg_read(12'h480, d);
      check_word("select 0-3 reset", 32'h0, d);
      reg_read(12'h484, d);
      check_word("select 4 reset", 32'h0, d);
      reg_write(12'h480, 32'hFFFFFFFF);
      reg_write(12'h484, 32'hFFFFFFFF);
      reg_write(12'h488, 32'hFFFFFFFF);
      reg_read(12'h480, d);
      check_word("select 0-3 fields", 32'h3F3F3F3F, d);
      @(posedge core_clk_in);
      #1;
      check_word("read data after slot", 32'h0, reg_rdata_out);
      reg_read(12'h484, d);
      check_word("select 4 field", 32'h0000003F, d);
      reg_read(12'h488, d);
      check_word("unmapped read", 32'h0, d);
      reg_write(12'h480, 32'h231D1205);
      reg_read(12'h480, d);
      check_word("select 0-3 walk", 32'h231D1205, d);
   endtask : test_registers

   task automatic test_code_sweep();
      int b;
      int ch;
      logic [4:0] e;
      for (int code = 0; code < 64; code++) begin
         ch = code % 5;
         b = src_bit(code);
         program_code(ch, 6'(code));
         e = 5'h00;
         if (b >= 0) e[ch] = 1'b1;
         drive((b >= 0) ? ~(25'h1 << b) : {25{1'b1}});
         check_chan("request from others", 5'h00, channel_request_out);
         check_chan("selected", e, channel_selected_out);
         if (b >= 0) begin
            drive(25'h1 << b);
            check_chan("request routed", e, channel_request_out);
         end
      end
   endtask : test_code_sweep

   task automatic test_mem_to_mem();
      program_code(1, CODE_ADC);
      drive({25{1'b1}});
      check_chan("request before copy mode", 5'h02, channel_request_out);
      @(posedge core_clk_in);
      mem_to_mem_in <= 5'h02;
      repeat (2) @(posedge core_clk_in);
      #1;
      check_chan("request in copy mode", 5'h00, channel_request_out);
      check_chan("selected in copy mode", 5'h00, channel_selected_out);
      @(posedge core_clk_in);
      mem_to_mem_in <= 5'h00;
      repeat (2) @(posedge core_clk_in);
      #1;
      check_chan("request after copy mode", 5'h02, channel_request_out);
   endtask : test_mem_to_mem

   // Software breaks the one-channel-per-source rule here on purpose.
   task automatic test_conflict();
      reg_write(12'h480, 32'h00200020);
      repeat (2) @(posedge core_clk_in);
      #1;
      check_word("conflict flag", 32'h1, {31'h0, source_conflict_out});
      program_code(0, CODE_TIMER_BASE);
      repeat (2) @(posedge core_clk_in);
      #1;
      check_word("conflict cleared", 32'h0, {31'h0, source_conflict_out});
   endtask : test_conflict

   // ----------------------------------------------------------------------
   // Clock, sequence, watchdog and verdict
   // ----------------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict

   initial begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end

   initial begin
      n_errors = 0;
      total_checks = 0;
      reset_n_in = 1'b0;
      reg_addr_in = 12'h0;
      reg_wdata_in = 32'h0;
      reg_write_in = 1'b0;
      reg_read_in = 1'b0;
      pattern = 25'h0;
      mem_to_mem_in = 5'h00;
      repeat (2) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      check_chan("request in reset", 5'h00, channel_request_out);
      test_registers();
      test_code_sweep();
      test_mem_to_mem();
      test_conflict();
      print_verdict();
   end

   // The sweep needs about 880 cycles; 8000 leaves a wide margin.
   initial begin
      repeat (8000) @(posedge core_clk_in);
      n_errors++;
      $display("watchdog expired");
      print_verdict();
   end
endmodule : testbench
